/* File: shared/nv_copy_pkg.sv */
/*
 * Constants and types for the nonvolatile register copy block.
 * Assumes a 100 MHz system clock; times are in nanoseconds.
 */
`default_nettype none
package nv_copy_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned RESTORE_COPY_TIME_NS = 200000;
   localparam int unsigned STORE_COPY_TIME_NS = 20000000;
   localparam int unsigned RESTORE_COPY_CYCLES = RESTORE_COPY_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned STORE_COPY_CYCLES = STORE_COPY_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned TIMER_W = 24;

   // ****************************************
   // Bus codes
   // ****************************************
   localparam logic [3:0] DEV_TYPE_ID = 4'h9;
   localparam logic [7:0] OP_RESTORE = 8'hb8;
   localparam logic [7:0] OP_STORE = 8'h48;
   localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
   localparam logic [3:0] BIT_CNT_ACK = 4'h9;

   // ****************************************
   // Registers
   // ****************************************
   localparam int unsigned REG_W = 16;
   localparam int unsigned PTR_W = 2;
   localparam logic [PTR_W-1:0] PTR_RST = 2'h0;
   localparam logic [REG_W-1:0] VOL_RST = 16'h0000;
   localparam logic [REG_W-1:0] NV_CFG_RST = 16'h0000;
   localparam logic [REG_W-1:0] NV_TLOW_RST = 16'h4b00;
   localparam logic [REG_W-1:0] NV_THIGH_RST = 16'h5000;
   localparam int unsigned LOCK_BIT_POS = 1;
   localparam int unsigned LOCKDOWN_BIT_POS = 2;

   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} copy_state_t;
   typedef enum logic {KIND_RESTORE, KIND_STORE} copy_kind_t;
endpackage
`default_nettype wire

/* File: rtl/i2c_cmd_rx.sv */
/*
 * Serial bus receiver: start/stop detection, address match, byte capture
 * and acknowledge drive. Assumes scl and sda already synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module i2c_cmd_rx (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [2:0] dev_addr,
   // Frame events
   output logic start_p,
   output logic stop_p,
   output logic cmd_p,
   output logic [7:0] cmd_byte
);
   import nv_copy_pkg::*;

   logic scl_prev_q, sda_prev_q, active_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic [1:0] byte_idx_q;
   logic scl_rise, scl_fall, start_det, stop_det, byte_end, addr_match;

   assign scl_rise = scl_i & ~scl_prev_q;
   assign scl_fall = ~scl_i & scl_prev_q;
   assign start_det = scl_i & scl_prev_q & sda_prev_q & ~sda_i;
   assign stop_det = scl_i & scl_prev_q & ~sda_prev_q & sda_i;
   assign byte_end = active_q & scl_fall & (bit_cnt_q == BIT_CNT_BYTE);
   assign addr_match = (shift_q[7:4] == DEV_TYPE_ID) && (shift_q[3:1] == dev_addr) && !shift_q[0];

   // ****************************************
   // Pin history
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         sda_o <= 1'b0;
      end else begin
         scl_prev_q <= scl_i;
         sda_prev_q <= sda_i;
         sda_o <= 1'b0;
      end
   end

   // ****************************************
   // Frame and bit tracking
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         active_q <= 1'b0;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         byte_idx_q <= 2'h0;
         sda_oe <= 1'b0;
      end else if (start_det) begin
         active_q <= 1'b1;
         bit_cnt_q <= 4'h0;
         byte_idx_q <= 2'h0;
         sda_oe <= 1'b0;
      end else if (stop_det) begin
         active_q <= 1'b0;
         bit_cnt_q <= 4'h0;
         sda_oe <= 1'b0;
      end else if (active_q) begin
         if (scl_rise && bit_cnt_q < BIT_CNT_BYTE) begin
            shift_q <= {shift_q[6:0], sda_i};
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end else if (scl_rise && bit_cnt_q == BIT_CNT_BYTE) begin
            bit_cnt_q <= BIT_CNT_ACK;
         end else if (byte_end) begin
            if (byte_idx_q == 2'h0) begin
               sda_oe <= addr_match;
               active_q <= addr_match;
            end else begin
               sda_oe <= 1'b1;
            end
            byte_idx_q <= (byte_idx_q == 2'h2) ? 2'h2 : byte_idx_q + 2'h1;
         end else if (scl_fall && bit_cnt_q == BIT_CNT_ACK) begin
            sda_oe <= 1'b0;
            bit_cnt_q <= 4'h0;
         end
      end
   end

   // ****************************************
   // Event pulses
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         start_p <= 1'b0;
         stop_p <= 1'b0;
         cmd_p <= 1'b0;
         cmd_byte <= 8'h00;
      end else begin
         start_p <= start_det;
         stop_p <= stop_det;
         cmd_p <= byte_end && !start_det && !stop_det && (byte_idx_q == 2'h1);
         if (byte_end && byte_idx_q == 2'h1) begin
            cmd_byte <= shift_q;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_addr_ack: assert property (byte_end && !start_det && !stop_det && byte_idx_q == 2'h0 && addr_match
      |=> sda_oe ##1 (sda_oe || !active_q || bit_cnt_q == 4'h0))
      else $error("matching address not acknowledged");
   a_addr_nack: assert property (byte_end && !start_det && !stop_det && byte_idx_q == 2'h0 && !addr_match
      |=> !sda_oe && !active_q)
      else $error("foreign address acknowledged");
   a_cmd_ack: assert property (cmd_p |-> sda_oe)
      else $error("command byte not acknowledged");
endmodule // i2c_cmd_rx
`default_nettype wire

/* File: rtl/nv_register_copy.sv */
/*
 * Copy command logic between working and nonvolatile configuration and
 * limit registers. Assumes synchronous bus pins and a 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Every reset starts a restore copy of nonvolatile into working registers without any bus command.
// - A write address byte 1001AAA0 matching the address pins is acknowledged.
// - Opcode b8h in place of a pointer byte selects the restore copy and is acknowledged.
// - After a taken restore opcode and Stop the restore runs self-timed within its time, busy set throughout.
// - A repeated Start after the restore opcode aborts it and leaves working registers unchanged.
// - Either opcode is ignored while busy, locked or locked down, yet still acknowledged.
// - Opcode 48h after the address byte selects the store copy and is acknowledged.
// - After a taken store opcode and Stop the store runs self-timed within its time, busy set meanwhile.
// - A repeated Start after the store opcode aborts it and leaves nonvolatile registers unchanged.
// - Restore maps each nonvolatile register onto its own working register.
// - A copy opcode leaves the register pointer unchanged.
module nv_register_copy #(
   parameter int unsigned RESTORE_CYCLES = nv_copy_pkg::RESTORE_COPY_CYCLES,
   parameter int unsigned STORE_CYCLES = nv_copy_pkg::STORE_COPY_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Serial bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [2:0] dev_addr,
   // Working register writes from the device
   input wire logic vol_wr_en,
   input wire logic [1:0] vol_wr_sel,
   input wire logic [nv_copy_pkg::REG_W-1:0] vol_wr_data,
   // Register contents and status
   output logic [nv_copy_pkg::REG_W-1:0] vol_cfg_q,
   output logic [nv_copy_pkg::REG_W-1:0] vol_tlow_q,
   output logic [nv_copy_pkg::REG_W-1:0] vol_thigh_q,
   output logic [nv_copy_pkg::REG_W-1:0] nv_cfg_q,
   output logic [nv_copy_pkg::REG_W-1:0] nv_tlow_q,
   output logic [nv_copy_pkg::REG_W-1:0] nv_thigh_q,
   output logic [nv_copy_pkg::PTR_W-1:0] pointer_q,
   output logic nv_busy_flag
);
   import nv_copy_pkg::*;

   copy_state_t state_q;
   copy_kind_t kind_q;
   logic [TIMER_W-1:0] timer_q;
   logic start_p, stop_p, cmd_p;
   logic [7:0] cmd_byte;
   logic is_copy_op, locked, done;

   i2c_cmd_rx u_rx (
      .clk(clk),
      .rst_b(rst_b),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .dev_addr(dev_addr),
      .start_p(start_p),
      .stop_p(stop_p),
      .cmd_p(cmd_p),
      .cmd_byte(cmd_byte)
   );

   assign is_copy_op = (cmd_byte == OP_RESTORE) || (cmd_byte == OP_STORE);
   assign locked = nv_cfg_q[LOCK_BIT_POS] | nv_cfg_q[LOCKDOWN_BIT_POS];
   assign done = (state_q == ST_RUN) && (timer_q == '0);

   // ****************************************
   // Copy sequencer
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= ST_RUN;
         kind_q <= KIND_RESTORE;
         timer_q <= TIMER_W'(RESTORE_CYCLES - 1);
         nv_busy_flag <= 1'b1;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (cmd_p && is_copy_op && !nv_busy_flag && !locked) begin
                  state_q <= ST_ARMED;
                  kind_q <= (cmd_byte == OP_STORE) ? KIND_STORE : KIND_RESTORE;
               end
            end
            ST_ARMED: begin
               if (start_p) begin
                  state_q <= ST_IDLE;
               end else if (stop_p) begin
                  state_q <= ST_RUN;
                  nv_busy_flag <= 1'b1;
                  timer_q <= (kind_q == KIND_STORE) ? TIMER_W'(STORE_CYCLES - 1)
                                                    : TIMER_W'(RESTORE_CYCLES - 1);
               end
            end
            ST_RUN: begin
               if (done) begin
                  state_q <= ST_IDLE;
                  nv_busy_flag <= 1'b0;
               end else begin
                  timer_q <= timer_q - 1'b1;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Working registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         vol_cfg_q <= VOL_RST;
         vol_tlow_q <= VOL_RST;
         vol_thigh_q <= VOL_RST;
      end else if (done && kind_q == KIND_RESTORE) begin
         vol_cfg_q <= nv_cfg_q;
         vol_tlow_q <= nv_tlow_q;
         vol_thigh_q <= nv_thigh_q;
      end else if (vol_wr_en && !nv_busy_flag && !locked) begin
         unique case (vol_wr_sel)
            2'h0: vol_cfg_q <= vol_wr_data;
            2'h1: vol_tlow_q <= vol_wr_data;
            2'h2: vol_thigh_q <= vol_wr_data;
            default: ;
         endcase
      end
   end

   // ****************************************
   // Nonvolatile registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         nv_cfg_q <= NV_CFG_RST;
         nv_tlow_q <= NV_TLOW_RST;
         nv_thigh_q <= NV_THIGH_RST;
      end else if (done && kind_q == KIND_STORE) begin
         nv_cfg_q <= vol_cfg_q;
         nv_tlow_q <= vol_tlow_q;
         nv_thigh_q <= vol_thigh_q;
      end
   end

   // ****************************************
   // Register pointer
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pointer_q <= PTR_RST;
      end else if (cmd_p && !is_copy_op) begin
         pointer_q <= cmd_byte[PTR_W-1:0];
      end
   end

   // ****************************************
   // Busy length monitor
   // ****************************************
   logic [TIMER_W-1:0] busy_len_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         busy_len_q <= '0;
      end else if (nv_busy_flag) begin
         busy_len_q <= busy_len_q + 1'b1;
      end else begin
         busy_len_q <= '0;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_reset_restore: assert property (done && kind_q == KIND_RESTORE
      |=> vol_cfg_q == $past(nv_cfg_q) && vol_tlow_q == $past(nv_tlow_q) && vol_thigh_q == $past(nv_thigh_q))
      else $error("restore copy mismatch");
   a_restore_start: assert property (state_q == ST_ARMED && kind_q == KIND_RESTORE && stop_p && !start_p
      |=> nv_busy_flag && timer_q == TIMER_W'(RESTORE_CYCLES - 1))
      else $error("restore not started on stop");
   a_busy_held: assert property (nv_busy_flag && !done |=> nv_busy_flag)
      else $error("busy dropped before completion");
   a_abort_sr: assert property (state_q == ST_ARMED && start_p
      |=> state_q == ST_IDLE ##1 !nv_busy_flag && $stable(vol_cfg_q) && $stable(nv_cfg_q))
      else $error("repeated start did not abort");
   a_ignore_locked: assert property (cmd_p && is_copy_op && (nv_busy_flag || locked)
      |=> state_q != ST_ARMED)
      else $error("copy opcode accepted while blocked");
   a_store_map: assert property (done && kind_q == KIND_STORE
      |=> nv_cfg_q == $past(vol_cfg_q) && nv_tlow_q == $past(vol_tlow_q) && nv_thigh_q == $past(vol_thigh_q))
      else $error("store copy mismatch");
   a_nv_only_store: assert property ((nv_cfg_q != $past(nv_cfg_q) || nv_tlow_q != $past(nv_tlow_q)
      || nv_thigh_q != $past(nv_thigh_q)) |-> $past(done) && $past(kind_q) == KIND_STORE)
      else $error("nonvolatile changed outside store");
   a_pointer_kept: assert property (cmd_p && is_copy_op |=> $stable(pointer_q))
      else $error("pointer changed by opcode");
   a_busy_clear: assert property (done |=> !nv_busy_flag && state_q == ST_IDLE)
      else $error("busy not cleared after copy");
   a_store_start: assert property (state_q == ST_ARMED && kind_q == KIND_STORE && stop_p && !start_p
      |=> nv_busy_flag && timer_q == TIMER_W'(STORE_CYCLES - 1))
      else $error("store not started on stop");
   a_restore_time: assert property (nv_busy_flag && kind_q == KIND_RESTORE
      |-> busy_len_q < TIMER_W'(RESTORE_CYCLES))
      else $error("restore copy overran its time");
   a_store_time: assert property (nv_busy_flag && kind_q == KIND_STORE
      |-> busy_len_q < TIMER_W'(STORE_CYCLES))
      else $error("store copy overran its time");
   a_busy_run: assert property (nv_busy_flag == (state_q == ST_RUN))
      else $error("busy flag out of step with copy");

   c_restore_done: cover property (done && kind_q == KIND_RESTORE && $past(state_q) == ST_RUN);
   c_store_done: cover property (done && kind_q == KIND_STORE);
   c_abort: cover property (state_q == ST_ARMED && start_p);
   c_ignored: cover property (cmd_p && is_copy_op && locked);
endmodule // nv_register_copy
`default_nettype wire

/* File: verification/bus_ctl_model.sv */
/*
 * Serial bus controller model that issues copy command frames.
 * Assumes an open-drain data wire with a pull-up, resolved outside.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_model (
   // Clock
   input wire logic clk,
   // Bus pins
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   // ****************************************
   // Bus phases
   // ****************************************
   localparam int unsigned QTR = 4;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic start_cond();
      sda_low = 1'b0;
      tick(QTR);
      scl = 1'b1;
      tick(QTR);
      sda_low = 1'b1;
      tick(QTR);
      scl = 1'b0;
      tick(QTR);
   endtask
   task automatic stop_cond();
      sda_low = 1'b1;
      tick(QTR);
      scl = 1'b1;
      tick(QTR);
      sda_low = 1'b0;
      tick(1);
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low = ~b[i];
         tick(QTR);
         scl = 1'b1;
         tick(2 * QTR);
         scl = 1'b0;
         tick(QTR);
      end
      sda_low = 1'b0;
      tick(QTR);
      scl = 1'b1;
      tick(QTR);
      ack = (sda === 1'b0);
      tick(QTR);
      scl = 1'b0;
      tick(QTR);
   endtask
   // Start, address, opcode, then Stop or repeated Start and Stop
   task automatic frame(input logic [7:0] a, input logic [7:0] op, input bit sr,
                        output logic ack_a, output logic ack_o);
      start_cond();
      send_byte(a, ack_a);
      send_byte(op, ack_o);
      if (sr) begin
         start_cond();
      end
      stop_cond();
   endtask
endmodule // bus_ctl_model
`default_nettype wire

/* File: verification/tb.sv */
/*
 * Self-checking testbench for the copy command logic.
 * Assumes the bus controller model and the design package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import nv_copy_pkg::*;
   // ****************************************
   // Setup
   // ****************************************
   localparam int unsigned RC = 20;
   localparam int unsigned SC = 2000;
   localparam logic [2:0] PINS = 3'h5;
   localparam logic [7:0] ADDR = {DEV_TYPE_ID, PINS, 1'b0};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic scl, sda_low, sda, sda_o, sda_oe, nv_busy_flag, ack_a, ack_o;
   logic vol_wr_en = 1'b0;
   logic [1:0] vol_wr_sel = 2'h0;
   logic [REG_W-1:0] vol_wr_data = 16'h0000;
   logic [REG_W-1:0] vol_cfg_q, vol_tlow_q, vol_thigh_q, nv_cfg_q, nv_tlow_q, nv_thigh_q;
   logic [PTR_W-1:0] pointer_q;
   int n_errors = 0;
   int tests_run = 0;
   always #5 clk = ~clk;
   assign sda = ~(sda_low | sda_oe);
   bus_ctl_model u_ctl (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
   nv_register_copy #(.RESTORE_CYCLES(RC), .STORE_CYCLES(SC)) dut (
      .clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .dev_addr(PINS), .vol_wr_en(vol_wr_en), .vol_wr_sel(vol_wr_sel), .vol_wr_data(vol_wr_data),
      .vol_cfg_q(vol_cfg_q), .vol_tlow_q(vol_tlow_q), .vol_thigh_q(vol_thigh_q), .nv_cfg_q(nv_cfg_q),
      .nv_tlow_q(nv_tlow_q), .nv_thigh_q(nv_thigh_q), .pointer_q(pointer_q), .nv_busy_flag(nv_busy_flag));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("errors=%0d comparisons=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [1:0] sel, input logic [15:0] d);
      vol_wr_en = 1'b1;
      vol_wr_sel = sel;
      vol_wr_data = d;
      u_ctl.tick(1);
      vol_wr_en = 1'b0;
      u_ctl.tick(1);
   endtask
   // Counts the cycles that busy stands once it has risen
   task automatic busy_len(output int cnt);
      int w;
      w = 0;
      cnt = 0;
      while (nv_busy_flag !== 1'b1 && w < 8) begin
         u_ctl.tick(1);
         w++;
      end
      while (nv_busy_flag === 1'b1 && cnt < SC + 10) begin
         u_ctl.tick(1);
         cnt++;
      end
   endtask
   task automatic cmd(input logic [7:0] op, input bit sr);
      u_ctl.frame(ADDR, op, sr, ack_a, ack_o);
      check(ack_a, 1'b1);
      check(ack_o, 1'b1);
      check(sda_o, 1'b0);
   endtask
   task automatic idle_check();
      u_ctl.tick(6);
      check(nv_busy_flag, 1'b0);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      int c;
      rst_b = 1'b0;
      u_ctl.tick(4);
      rst_b = 1'b1;
      check(nv_busy_flag, 1'b1);
      busy_len(c);
      check(c, RC);
      check(vol_cfg_q, NV_CFG_RST);
      check(vol_tlow_q, NV_TLOW_RST);
      check(vol_thigh_q, NV_THIGH_RST);
   endtask
   task automatic t_address();
      u_ctl.frame({DEV_TYPE_ID, ~PINS, 1'b0}, OP_STORE, 1'b0, ack_a, ack_o);
      check(ack_a, 1'b0);
      check(ack_o, 1'b0);
      idle_check();
      u_ctl.frame(ADDR, 8'h02, 1'b0, ack_a, ack_o);
      check(ack_a, 1'b1);
      check(pointer_q, 2'h2);
   endtask
   task automatic t_store();
      int c;
      wr(2'h0, 16'h0010);
      wr(2'h1, 16'h1234);
      wr(2'h2, 16'h5678);
      cmd(OP_STORE, 1'b0);
      busy_len(c);
      check(c, SC);
      check(nv_cfg_q, 16'h0010);
      check(nv_tlow_q, 16'h1234);
      check(nv_thigh_q, 16'h5678);
      check(pointer_q, 2'h2);
   endtask
   task automatic t_restore();
      int c;
      wr(2'h0, 16'h0001);
      wr(2'h1, 16'h0bad);
      wr(2'h2, 16'hbeef);
      cmd(OP_RESTORE, 1'b0);
      busy_len(c);
      check(c, RC);
      check(vol_cfg_q, 16'h0010);
      check(vol_tlow_q, 16'h1234);
      check(vol_thigh_q, 16'h5678);
      check(pointer_q, 2'h2);
   endtask
   task automatic t_abort();
      wr(2'h1, 16'haaaa);
      cmd(OP_STORE, 1'b1);
      u_ctl.tick(SC + 10);
      check(nv_tlow_q, 16'h1234);
      cmd(OP_RESTORE, 1'b1);
      u_ctl.tick(RC + 10);
      check(vol_tlow_q, 16'haaaa);
   endtask
   task automatic t_busy();
      int c;
      cmd(OP_STORE, 1'b0);
      cmd(OP_STORE, 1'b0);
      busy_len(c);
      idle_check();
      check(nv_tlow_q, 16'haaaa);
   endtask
   task automatic t_lock();
      int c;
      for (int i = 0; i < 2; i++) begin
         t_reset();
         wr(2'h0, 16'h0001 << (i == 0 ? LOCK_BIT_POS : LOCKDOWN_BIT_POS));
         cmd(OP_STORE, 1'b0);
         busy_len(c);
         wr(2'h1, 16'h7777);
         cmd(OP_RESTORE, 1'b0);
         idle_check();
         cmd(OP_STORE, 1'b0);
         idle_check();
         check(nv_tlow_q, NV_TLOW_RST);
      end
   endtask
   initial begin
      #400000;
      n_errors++;
      conclude();
   end
   initial begin
      t_reset();
      t_address();
      t_store();
      t_restore();
      t_abort();
      t_busy();
      t_lock();
      conclude();
   end
endmodule // tb
`default_nettype wire
